// >>> rtl/mpks_cfg.svh
// Timing constants for the power key sequencer
// Assumes a 10 MHz ref_clk; times are kept in milliseconds
`ifndef MPKS_CFG_SVH
`define MPKS_CFG_SVH
`define MPKS_CLK_HZ          10000000
`define MPKS_CYC_PER_MS      (`MPKS_CLK_HZ / 1000)
`define MPKS_ON_MIN_MS       100
`define MPKS_OFF_MIN_MS      2500
`define MPKS_OFF_MAX_MS      3000
`define MPKS_KEY_OFF_MS      22000
`define MPKS_CMD_OFF_MS      15000
`define MPKS_RST_MS          1000
`define MPKS_RESTART_MS      27000
`define MPKS_ON_MIN_CYC      (`MPKS_ON_MIN_MS * `MPKS_CYC_PER_MS)
`define MPKS_OFF_MIN_CYC     (`MPKS_OFF_MIN_MS * `MPKS_CYC_PER_MS)
`define MPKS_OFF_MAX_CYC     (`MPKS_OFF_MAX_MS * `MPKS_CYC_PER_MS)
`define MPKS_KEY_OFF_CYC     (`MPKS_KEY_OFF_MS * `MPKS_CYC_PER_MS)
`define MPKS_CMD_OFF_CYC     (`MPKS_CMD_OFF_MS * `MPKS_CYC_PER_MS)
`define MPKS_RST_CYC         (`MPKS_RST_MS * `MPKS_CYC_PER_MS)
`define MPKS_RESTART_CYC     (`MPKS_RESTART_MS * `MPKS_CYC_PER_MS)
`endif

// >>> rtl/mpks_low_timer.sv
// Measures how long an active-low input has been held low
// Counter saturates; a one-cycle release pulse reports the final length
`timescale 1ns/1ps
module mpks_low_timer #(
    parameter int W = 32
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_n,
    output logic [W-1:0]      len_q,
    output logic              rel_q
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] len;
        logic         rel;
        logic         prev_n;
    } mpks_lt_s;
    mpks_lt_s s_q;
    mpks_lt_s s_d;

    always_comb
    begin
        s_d        = s_q;
        s_d.prev_n = in_n;
        s_d.rel    = 1'b0;
        if (!in_n)
        begin
            if (s_q.cnt != {W{1'b1}})
                s_d.cnt = s_q.cnt + W'(1);
        end
        else
        begin
            s_d.cnt = '0;
            if (!s_q.prev_n)
            begin
                s_d.len = s_q.cnt;
                s_d.rel = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            s_q <= '{cnt: '0, len: '0, rel: 1'b0, prev_n: 1'b1};
        else
            s_q <= s_d;
    end

    assign len_q = s_q.len;
    assign rel_q = s_q.rel;
endmodule : mpks_low_timer

// >>> rtl/mpks_pkg.sv
// Types for the power key sequencer
// Used together with mpks_cfg.svh
package mpks_pkg;
    typedef enum logic [5:0] {
        MPKS_OFF      = 6'b00_0001,
        MPKS_RUN      = 6'b00_0010,
        MPKS_DOWN     = 6'b00_0100,
        MPKS_RESTART  = 6'b00_1000,
        MPKS_BOOT     = 6'b01_0000,
        MPKS_RST_HOLD = 6'b10_0000
    } mpks_state_e;

    typedef struct packed {
        logic powered;
        logic port_ready;
        logic busy;
    } mpks_status_s;
endpackage : mpks_pkg

// >>> rtl/mpks_sequencer.sv
// Power key and reset sequencer of the modem module
// Inputs synchronous to ref_clk; the pad pull-up is modelled by key_oe_n
`timescale 1ns/1ps
`include "mpks_cfg.svh"
module mpks_sequencer #(
    parameter int KEY_OFF_CYC = `MPKS_KEY_OFF_CYC,
    parameter int CMD_OFF_CYC = `MPKS_CMD_OFF_CYC,
    parameter int RESTART_CYC = `MPKS_RESTART_CYC,
    parameter int RST_CYC     = `MPKS_RST_CYC,
    parameter int ON_MIN_CYC  = `MPKS_ON_MIN_CYC,
    parameter int OFF_MIN_CYC = `MPKS_OFF_MIN_CYC,
    parameter int OFF_MAX_CYC = `MPKS_OFF_MAX_CYC
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          key_in_n,
    input  wire logic          key_oe_n,
    input  wire logic          sys_rst_n,
    input  wire logic          shutdown_command,
    input  wire logic          restart_command,
    output mpks_pkg::mpks_status_s status,
    output mpks_pkg::mpks_state_e  state
);
    localparam int W = 32;

    typedef struct packed {
        mpks_pkg::mpks_state_e st;
        logic [W-1:0]          tmr;
        mpks_pkg::mpks_status_s sts;
    } mpks_seq_s;
    mpks_seq_s s_q;
    mpks_seq_s s_d;

    logic         key_n;
    logic [W-1:0] key_len;
    logic         key_rel;
    logic [W-1:0] rst_len;
    logic         rst_rel;

    // Undriven key floats high through the pull-up
    assign key_n = key_oe_n | key_in_n;

    mpks_low_timer #(.W(W)) u_key (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .in_n    (key_n),
        .len_q   (key_len),
        .rel_q   (key_rel)
    );

    mpks_low_timer #(.W(W)) u_rst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .in_n    (sys_rst_n),
        .len_q   (rst_len),
        .rel_q   (rst_rel)
    );

    always_comb
    begin
        s_d     = s_q;
        if (s_q.tmr != '0)
            s_d.tmr = s_q.tmr - W'(1);
        case (s_q.st)
            mpks_pkg::MPKS_OFF:
            begin
                // Acting on release keeps a long press from also powering off
                if (key_rel && key_len >= W'(ON_MIN_CYC))
                begin
                    s_d.st  = mpks_pkg::MPKS_RUN;
                end
            end
            mpks_pkg::MPKS_RUN:
            begin
                if (key_rel && key_len >= W'(OFF_MIN_CYC)
                    && key_len <= W'(OFF_MAX_CYC))
                begin
                    s_d.st  = mpks_pkg::MPKS_DOWN;
                    s_d.tmr = W'(KEY_OFF_CYC);
                end
                else if (shutdown_command)
                begin
                    s_d.st  = mpks_pkg::MPKS_DOWN;
                    s_d.tmr = W'(CMD_OFF_CYC);
                end
                else if (restart_command)
                begin
                    s_d.st  = mpks_pkg::MPKS_RESTART;
                    s_d.tmr = W'(RESTART_CYC);
                end
                else if (rst_rel && rst_len >= W'(RST_CYC))
                begin
                    s_d.st  = mpks_pkg::MPKS_RST_HOLD;
                end
            end
            mpks_pkg::MPKS_DOWN:
            begin
                if (s_q.tmr == W'(1))
                    s_d.st = mpks_pkg::MPKS_OFF;
            end
            mpks_pkg::MPKS_RESTART:
            begin
                if (s_q.tmr == W'(1))
                    s_d.st = mpks_pkg::MPKS_RUN;
            end
            mpks_pkg::MPKS_RST_HOLD:
            begin
                // Reboot time after a reset pulse is not bounded; reuse 27 s
                s_d.st  = mpks_pkg::MPKS_BOOT;
                s_d.tmr = W'(RESTART_CYC);
            end
            mpks_pkg::MPKS_BOOT:
            begin
                if (s_q.tmr == W'(1))
                    s_d.st = mpks_pkg::MPKS_RUN;
            end
            default:
            begin
                s_d.st = mpks_pkg::MPKS_OFF;
            end
        endcase
        s_d.sts.powered    = (s_d.st != mpks_pkg::MPKS_OFF);
        s_d.sts.port_ready = (s_d.st == mpks_pkg::MPKS_RUN);
        s_d.sts.busy       = s_d.sts.powered && !s_d.sts.port_ready;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            s_q <= '{st: mpks_pkg::MPKS_OFF, tmr: '0, sts: '0};
        else
            s_q <= s_d;
    end

    assign status = s_q.sts;
    assign state  = s_q.st;

    // Cycles spent powering down; only the checks read it, so it stays
    // outside the state struct and costs nothing once checks are gone
    logic [W-1:0] down_cnt;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || s_q.st != mpks_pkg::MPKS_DOWN)
            down_cnt <= '0;
        else
            down_cnt <= down_cnt + W'(1);
    end

    // Either shutdown path lasts at least the shorter command time
    chk_down_min_time: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_q.st == mpks_pkg::MPKS_DOWN && s_d.st == mpks_pkg::MPKS_OFF)
        |-> down_cnt + W'(1) >= W'(CMD_OFF_CYC))
        else $error("shutdown ended early");

    chk_key_off_load: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_q.st == mpks_pkg::MPKS_RUN && key_rel
         && key_len >= W'(OFF_MIN_CYC) && key_len <= W'(OFF_MAX_CYC))
        |=> (s_q.st == mpks_pkg::MPKS_DOWN
             && s_q.tmr == W'(KEY_OFF_CYC)))
        else $error("key shutdown time not loaded");

    chk_cmd_off_load: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_q.st == mpks_pkg::MPKS_RUN && shutdown_command && !key_rel)
        |=> (s_q.st == mpks_pkg::MPKS_DOWN
             && s_q.tmr == W'(CMD_OFF_CYC)))
        else $error("command shutdown time not loaded");

    // Release pulse lags the pin by one edge, so judge on the pulse itself
    chk_power_on_key: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_q.st == mpks_pkg::MPKS_OFF && key_rel)
        |=> (status.powered == (key_len >= W'(ON_MIN_CYC))))
        else $error("power on decision wrong");

    chk_restart_quiet: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_q.st == mpks_pkg::MPKS_RUN && restart_command && !key_rel
         && !shutdown_command)
        |=> !status.port_ready [*8])
        else $error("port ready too soon");

    chk_reset_pulse: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_q.st == mpks_pkg::MPKS_RUN && rst_rel && rst_len >= W'(RST_CYC)
         && !key_rel && !shutdown_command && !restart_command)
        |=> s_q.st == mpks_pkg::MPKS_RST_HOLD ##1
            s_q.st == mpks_pkg::MPKS_BOOT)
        else $error("reset pulse ignored");

    // A floating pad two edges back can never end in a release pulse
    chk_key_float: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(key_oe_n, 2) |-> !key_rel)
        else $error("undriven key read as low");

    // Commands only act while running; a stray one must not wake the part
    chk_cmd_when_off: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_q.st == mpks_pkg::MPKS_OFF && !key_rel
         && (shutdown_command || restart_command))
        |=> s_q.st == mpks_pkg::MPKS_OFF)
        else $error("command acted while off");
endmodule : mpks_sequencer

// >>> verification/module_power_key_sequencer_test.sv
// Bench for the power key sequencer with shortened timers
// Assumes the host model drives key and reset; bench drives commands
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module module_power_key_sequencer_test;
    logic ref_clk = 1'b0;
    // Shortened timers keep the whole run small
    localparam int KEY_OFF   = 40;
    localparam int CMD_OFF   = 30;
    localparam int RESTART_T = 50;
    localparam int RST_T     = 10;
    localparam int ON_MIN    = 4;
    localparam int OFF_MIN   = 20;
    localparam int OFF_MAX   = 24;
    logic rst_n;
    logic key_in_n, key_oe_n, sys_rst_n;
    logic shutdown_command;
    logic restart_command;
    mpks_pkg::mpks_status_s status;
    mpks_pkg::mpks_state_e  state;
    int fails = 0;
    int comparisons = 0;

    always #50 ref_clk = ~ref_clk;

    mpks_host u_host (.ref_clk(ref_clk), .key_in_n(key_in_n),
        .key_oe_n(key_oe_n), .sys_rst_n(sys_rst_n));

    mpks_sequencer #(.KEY_OFF_CYC(KEY_OFF), .CMD_OFF_CYC(CMD_OFF),
        .RESTART_CYC(RESTART_T), .RST_CYC(RST_T), .ON_MIN_CYC(ON_MIN),
        .OFF_MIN_CYC(OFF_MIN), .OFF_MAX_CYC(OFF_MAX))
    u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .key_in_n(key_in_n),
        .key_oe_n(key_oe_n), .sys_rst_n(sys_rst_n),
        .shutdown_command(shutdown_command),
        .restart_command(restart_command), .status(status), .state(state));

    task automatic test_done;
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : settle

    // Bounded wait; a hang counts as a mismatch and closes the run
    task automatic wait_st(input mpks_pkg::mpks_state_e st, input int max);
        int i;
        i = 0;
        while (state !== st && i < max)
        begin
            settle(1);
            i++;
        end
        if (state !== st)
        begin
            fails++;
            test_done();
        end
    endtask : wait_st

    // Timers are exact; one cycle slack for the release latency
    task automatic dur(input mpks_pkg::mpks_state_e st, input int exp);
        int n;
        n = 0;
        while (state === st && n < 1000)
        begin
            settle(1);
            n++;
        end
        `CHK(n >= exp - 1 && n <= exp + 1, 1'b1)
        if (n >= 1000)
            test_done();
    endtask : dur

    // Expected state after a press of n cycles while off
    function automatic mpks_pkg::mpks_state_e exp_on(input int n);
        exp_on = (n >= ON_MIN) ? mpks_pkg::MPKS_RUN : mpks_pkg::MPKS_OFF;
    endfunction : exp_on

    task automatic power_on;
        int n;
        n = 6 + $urandom % 15;
        u_host.press(n, 1'b1);
        wait_st(mpks_pkg::MPKS_RUN, 6);
        `CHK(state, exp_on(n))
        `CHK(status.powered, 1'b1)
        `CHK(status.port_ready, 1'b1)
        `CHK(status.busy, 1'b0)
    endtask : power_on

    task automatic pulse_cmd(input logic rst_cmd);
        @(posedge ref_clk);
        #1;
        if (rst_cmd)
            restart_command = 1'b1;
        else
            shutdown_command = 1'b1;
        @(posedge ref_clk);
        #1;
        restart_command  = 1'b0;
        shutdown_command = 1'b0;
    endtask : pulse_cmd

    initial
    begin
        rst_n            = 1'b0;
        shutdown_command = 1'b0;
        restart_command  = 1'b0;
        void'($urandom(61092));
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        u_host.press(20, 1'b0);
        settle(4);
        `CHK(state, mpks_pkg::MPKS_OFF)
        u_host.press(2, 1'b1);
        settle(4);
        `CHK(state, exp_on(2))
        power_on();
        u_host.press(12, 1'b1);
        settle(4);
        `CHK(state, mpks_pkg::MPKS_RUN)
        u_host.press(30, 1'b1);
        settle(4);
        `CHK(state, mpks_pkg::MPKS_RUN)
        u_host.press(OFF_MIN + 2 + $urandom % 3, 1'b1);
        wait_st(mpks_pkg::MPKS_DOWN, 6);
        dur(mpks_pkg::MPKS_DOWN, KEY_OFF);
        `CHK(state, mpks_pkg::MPKS_OFF)
        pulse_cmd(1'b0);
        settle(3);
        `CHK(state, mpks_pkg::MPKS_OFF)
        power_on();
        pulse_cmd(1'b0);
        wait_st(mpks_pkg::MPKS_DOWN, 4);
        dur(mpks_pkg::MPKS_DOWN, CMD_OFF);
        `CHK(state, mpks_pkg::MPKS_OFF)
        power_on();
        pulse_cmd(1'b1);
        wait_st(mpks_pkg::MPKS_RESTART, 4);
        `CHK(status.port_ready, 1'b0)
        `CHK(status.busy, 1'b1)
        dur(mpks_pkg::MPKS_RESTART, RESTART_T);
        `CHK(state, mpks_pkg::MPKS_RUN)
        u_host.rst_pulse(5);
        settle(4);
        `CHK(state, mpks_pkg::MPKS_RUN)
        u_host.rst_pulse(15);
        wait_st(mpks_pkg::MPKS_RST_HOLD, 6);
        settle(2);
        `CHK(state !== mpks_pkg::MPKS_RUN, 1'b1)
        wait_st(mpks_pkg::MPKS_RUN, 80);
        test_done();
    end
endmodule : module_power_key_sequencer_test

// >>> verification/mpks_host.sv
// Host model: drives the power key and the system reset line
// Assumes ref_clk from the bench; requests change 1 ns after an edge
`timescale 1ns/1ps
module mpks_host (
    input  wire logic ref_clk,
    output logic      key_in_n,
    output logic      key_oe_n,
    output logic      sys_rst_n
);
    // Supply is never removed in this model
    initial
    begin
        key_in_n  = 1'b1;
        key_oe_n  = 1'b1;
        sys_rst_n = 1'b1;
    end

    // Low pulse of n cycles; drv=0 leaves pad floating as a hazard case
    task automatic press(input int n, input logic drv);
        @(posedge ref_clk);
        #1;
        key_oe_n = ~drv;
        key_in_n = 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
        key_oe_n = 1'b1;
        key_in_n = 1'b1; // Pull-up level once released
    endtask : press

    // Caller spaces this well after power-on
    task automatic rst_pulse(input int n);
        @(posedge ref_clk);
        #1;
        sys_rst_n = 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
        sys_rst_n = 1'b1;
    endtask : rst_pulse
endmodule : mpks_host
